/* rtl/lpr_defines.vh */
`ifndef LPR_DEFINES_VH
`define LPR_DEFINES_VH
// ----------------------------------------
// register indices at data port 3C5h
// ----------------------------------------
`define LPR_IDX_SEQ 8'h34
`define LPR_IDX_HHI 8'h3E
`define LPR_IDX_HLO 8'h3F
`define LPR_IDX_R1L 8'h40
`define LPR_IDX_R1H 8'h41
`define LPR_IDX_R2L 8'h42
`define LPR_IDX_R2H 8'h43
`define LPR_IDX_R1O 8'h44
`define LPR_IDX_OVF 8'h45
`define LPR_IDX_WBL 8'h46
`define LPR_IDX_WBH 8'h47
`define LPR_IDX_WBO 8'h48
`define LPR_IDX_WOV 8'h49
// ----------------------------------------
// index base and count of the register store
// ----------------------------------------
`define LPR_STORE_BASE 8'h40
`define LPR_STORE_LAST 8'h49
`define LPR_STORE_AW 4
`define LPR_STORE_DEPTH 10
`define LPR_STORE_BASE_LO 4'h0
// ----------------------------------------
// reset values
// ----------------------------------------
`define LPR_SEQ_RST 8'h80
`define LPR_HHI_RST 8'h00
`define LPR_HLO_RST 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define LPR_SEQ_HW 7
`define LPR_SEQ_LPW 6
`define LPR_HHI_DES 7
`define LPR_HHI_GFLIP 5
`define LPR_HHI_VFLIP 4
`define LPR_HHI_FPD 3
`define LPR_HHI_FREE 2
`define LPR_HHI_W 6
`define LPR_RFC_VRE 7
`define LPR_PTYPE_DUAL_SCAN_PASSIVE_PANEL 2'h1
// ----------------------------------------
// timing counts, in system clock cycles
// ----------------------------------------
`define LPR_LP_NARROW 6'h10
`define LPR_LP_WIDE 6'h20
`define LPR_FREE_LP_PERIOD 11'h400
`endif

/* rtl/lpr_panel_regs.v */
`include "lpr_defines.vh"

// Function
// [RQ1] indexed registers at port 3C5h, read/write
// [RQ2] sequence bit 7 picks hardware sequencing
// [RQ3] step codes 10/11 give 4/8 frames
// [RQ4] codes 00/01 give 1/2 frames, hardware only
// [RQ5] blink code sets cursor/character periods
// [RQ6] line pulse width 16 or 32 clocks
// [RQ7] bits 5:4 extra pulses, odd frames
// [RQ8] bits 3:0 extra pulses, even/decoupled frames
// [RQ9] height bit 7 routes enable or M-signal
// [RQ10] flip/detect bits cleared when done
// [RQ11] height bit 2 enables free-running pulse
// [RQ12] software programs even half-height value
// [RQ13] first start serves upper half when decoupled
// [RQ14] first start built from overflow and bytes
// [RQ15] second start for lower half, decoupled only
// [RQ16] first offset maps to bits 12:3
// [RQ17] write start bytes drive bits 18:3
// [RQ18] write overflow drives bits 21:19
// [RQ19] decoupled refresh is refresh bit 7
// [RQ20] software initialises undefined registers first
module lpr_panel_regs (
  input wire clock_i, // system clock, 100 MHz
  input wire reset_i, // synchronous reset, active high
  input wire [7:0] index_i, // register index
  input wire data_wr_i, // write strobe on port 3C5h
  input wire data_rd_i, // read strobe on port 3C5h
  input wire [7:0] data_i, // write byte
  input wire [7:0] refresh_ctrl_i, // refresh control register value
  input wire [1:0] panel_type_i, // panel type code
  input wire [1:0] step_code_i, // power step interval field
  input wire [1:0] blink_code_i, // blink rate field
  input wire vsync_pulse_i, // one pulse per vertical frame
  input wire line_start_i, // pulse at start of each panel line
  input wire frame_odd_i, // current frame is odd
  input wire display_enable_i, // display enable signal
  input wire m_signal_i, // alternating M-signal
  input wire power_request_i, // level: panel should be on
  input wire gflip_done_i, // graphics queue flip done pulse
  input wire vflip_done_i, // video queue flip done pulse
  input wire frame_pulse_seen_i, // frame pulse detected pulse
  output reg [7:0] data_o, // read byte
  output reg data_valid_o, // read byte valid, one cycle
  output reg hw_power_sequence_select_o, // hardware sequencing chosen
  output reg panel_timing_enable_o, // panel timing enable
  output reg panel_bias_enable_o, // panel bias enable
  output reg panel_ctrl_enable_o, // panel control signals enable
  output reg panel_supply_enable_o, // panel supply enable
  output reg cursor_blink_o, // cursor blink phase
  output reg char_blink_o, // character blink phase
  output reg line_pulse_o, // passive panel line pulse
  output reg shared_pin_o, // enable or M-signal output
  output reg graphics_queue_flip_o, // flip request level
  output reg video_queue_flip_o, // flip request level
  output reg frame_pulse_detect_o, // detect request level
  output reg [9:0] panel_height_o, // half height value
  output reg [18:0] first_read_start_o, // first read start address
  output reg [18:0] second_read_start_o, // second read start address
  output reg second_read_valid_o, // second start in use
  output reg [12:0] first_read_offset_o, // first offset as address
  output reg [21:0] write_start_o // write start address
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [7:0] seq_reg; // sequence and line pulse control
  reg [5:0] hhi_reg; // height high bits 7..2 minus bit 6 in bit 6 slot
  reg [1:0] hgt_hi_reg; // height bits 9:8
  reg [7:0] hlo_reg; // height low byte
  reg [7:0] r1l_reg, r1h_reg, r2l_reg, r2h_reg, r1o_reg, ovf_reg; // shadows
  reg [7:0] wbl_reg, wbh_reg, wov_reg; // write address shadows
  reg rd_pend_reg; // read pending, flop register or store
  reg [7:0] direct_reg; // directly decoded read byte
  reg direct_hit_reg; // read index outside the store
  wire decoupled = refresh_ctrl_i[`LPR_RFC_VRE]; // RQ19
  wire dual_scan_passive_panel = (panel_type_i == `LPR_PTYPE_DUAL_SCAN_PASSIVE_PANEL);
  wire in_store = (index_i >= `LPR_STORE_BASE) && (index_i <= `LPR_STORE_LAST);
  wire [3:0] store_addr = index_i[3:0] - `LPR_STORE_BASE_LO;
  wire [7:0] store_q;

  // ----------------------------------------
  // undefined-at-reset registers live in the store; shadows feed address outputs
  // ----------------------------------------
  lpr_store u_store (
    .clock_i(clock_i),
    .wr_en_i(data_wr_i & in_store),
    .wr_addr_i(store_addr),
    .wr_data_i(data_i),
    .rd_addr_i(store_addr),
    .rd_data_o(store_q)
  );

  // shadow copies of the store, so addresses are available every cycle
  always @(posedge clock_i)
  begin
    if (data_wr_i) // RQ1
    begin
      case (index_i)
        `LPR_IDX_R1L: r1l_reg <= data_i;
        `LPR_IDX_R1H: r1h_reg <= data_i;
        `LPR_IDX_R2L: r2l_reg <= data_i;
        `LPR_IDX_R2H: r2h_reg <= data_i;
        `LPR_IDX_R1O: r1o_reg <= data_i;
        `LPR_IDX_OVF: ovf_reg <= data_i;
        `LPR_IDX_WBL: wbl_reg <= data_i;
        `LPR_IDX_WBH: wbh_reg <= data_i;
        `LPR_IDX_WOV: wov_reg <= data_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // reset-defined registers; done beats clear wins set
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      seq_reg <= `LPR_SEQ_RST;
      hhi_reg <= 6'h00;
      hgt_hi_reg <= 2'h0;
      hlo_reg <= `LPR_HLO_RST;
    end
    else
    begin
      if (data_wr_i && index_i == `LPR_IDX_SEQ)
      begin
        seq_reg <= data_i; // RQ2
      end
      if (data_wr_i && index_i == `LPR_IDX_HLO)
      begin
        hlo_reg <= data_i; // RQ12
      end
      if (data_wr_i && index_i == `LPR_IDX_HHI)
      begin
        hgt_hi_reg <= data_i[1:0]; // RQ12
        hhi_reg[5] <= data_i[`LPR_HHI_DES]; // RQ9
        hhi_reg[0] <= data_i[`LPR_HHI_FREE]; // RQ11
      end
      // request bits: software sets, hardware clears when done
      hhi_reg[3] <= gflip_done_i ? 1'b0 :
        ((data_wr_i && index_i == `LPR_IDX_HHI && data_i[`LPR_HHI_GFLIP]) | hhi_reg[3]); // RQ10
      hhi_reg[2] <= vflip_done_i ? 1'b0 :
        ((data_wr_i && index_i == `LPR_IDX_HHI && data_i[`LPR_HHI_VFLIP]) | hhi_reg[2]); // RQ10
      hhi_reg[1] <= frame_pulse_seen_i ? 1'b0 :
        ((data_wr_i && index_i == `LPR_IDX_HHI && data_i[`LPR_HHI_FPD]) | hhi_reg[1]); // RQ10
      hhi_reg[4] <= 1'b0;
    end
  end

  // ----------------------------------------
  // read path: flop registers answer two cycles after the strobe, store too
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      rd_pend_reg <= 1'b0;
      direct_hit_reg <= 1'b0;
      direct_reg <= 8'h00;
      data_o <= 8'h00;
      data_valid_o <= 1'b0;
    end
    else
    begin
      rd_pend_reg <= data_rd_i;
      direct_hit_reg <= ~in_store;
      case (index_i)
        `LPR_IDX_SEQ: direct_reg <= seq_reg;
        `LPR_IDX_HHI: direct_reg <= {hhi_reg[5], 1'b0, hhi_reg[3:1], hhi_reg[0], hgt_hi_reg};
        `LPR_IDX_HLO: direct_reg <= hlo_reg;
        default: direct_reg <= 8'h00; // unmapped index reads zero
      endcase
      data_valid_o <= rd_pend_reg; // RQ1
      if (rd_pend_reg)
      begin
        data_o <= direct_hit_reg ? direct_reg : store_q;
      end
    end
  end

  // ----------------------------------------
  // frame counting for power steps and blink
  // ----------------------------------------
  reg [2:0] step_frames_reg; // frames elapsed in current step
  reg [2:0] power_step_reg; // number of enables asserted, 0..4
  reg [7:0] blink_cnt_reg; // frame count for blink, wide enough for code 11
  reg [3:0] step_len; // frames per step
  always @*
  begin
    case (step_code_i)
      2'h0: step_len = 4'h1; // RQ4
      2'h1: step_len = 4'h2; // RQ4
      2'h2: step_len = 4'h4; // RQ3
      default: step_len = 4'h8; // RQ3
    endcase
  end

  // hardware sequencing walks one enable per step; software drives all at once
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      step_frames_reg <= 3'h0;
      power_step_reg <= 3'h0;
    end
    else if (!seq_reg[`LPR_SEQ_HW])
    begin
      power_step_reg <= power_request_i ? 3'h4 : 3'h0; // RQ2
      step_frames_reg <= 3'h0;
    end
    else if ((power_request_i && power_step_reg != 3'h4) ||
             (!power_request_i && power_step_reg != 3'h0))
    begin
      if (vsync_pulse_i)
      begin
        if ({1'b0, step_frames_reg} == step_len - 4'h1) // RQ4
        begin
          step_frames_reg <= 3'h0;
          power_step_reg <= power_request_i ? power_step_reg + 3'h1 : power_step_reg - 3'h1;
        end
        else
        begin
          step_frames_reg <= step_frames_reg + 3'h1;
        end
      end
    end
    else
    begin
      step_frames_reg <= 3'h0;
    end
  end

  // blink counter: cursor toggles at bit n, character at bit n+1
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      blink_cnt_reg <= 8'h00;
    end
    else if (vsync_pulse_i)
    begin
      blink_cnt_reg <= blink_cnt_reg + 8'h01; // RQ5
    end
  end

  // ----------------------------------------
  // passive panel line pulse generator
  // ----------------------------------------
  reg [5:0] lp_cnt_reg; // clocks left in pulse
  reg [4:0] extra_reg; // extra pulses still owed
  reg [10:0] free_cnt_reg; // free-running period count
  wire [5:0] lp_width = seq_reg[`LPR_SEQ_LPW] ? `LPR_LP_WIDE : `LPR_LP_NARROW; // RQ6
  wire [3:0] extra_num = (decoupled || !frame_odd_i) ? seq_reg[3:0] :
    {2'h0, seq_reg[5:4]}; // RQ7 RQ8
  wire free_fire = hhi_reg[0] && (free_cnt_reg == `LPR_FREE_LP_PERIOD - 11'h1); // RQ11
  // extra pulses follow back to back after the frame's last line
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      lp_cnt_reg <= 6'h00;
      extra_reg <= 5'h00;
      free_cnt_reg <= 11'h000;
    end
    else
    begin
      free_cnt_reg <= (hhi_reg[0] && !free_fire) ? free_cnt_reg + 11'h1 : 11'h000;
      if (vsync_pulse_i && dual_scan_passive_panel)
      begin
        extra_reg <= {1'b0, extra_num}; // RQ7 RQ8
      end
      if (line_start_i || free_fire)
      begin
        lp_cnt_reg <= lp_width; // RQ6
      end
      else if (lp_cnt_reg != 6'h00)
      begin
        lp_cnt_reg <= lp_cnt_reg - 6'h01;
      end
      else if (extra_reg != 5'h00 && !vsync_pulse_i)
      begin
        lp_cnt_reg <= lp_width;
        extra_reg <= extra_reg - 5'h01;
      end
    end
  end

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      hw_power_sequence_select_o <= 1'b1;
      panel_timing_enable_o <= 1'b0;
      panel_bias_enable_o <= 1'b0;
      panel_ctrl_enable_o <= 1'b0;
      panel_supply_enable_o <= 1'b0;
      cursor_blink_o <= 1'b0;
      char_blink_o <= 1'b0;
      line_pulse_o <= 1'b0;
      shared_pin_o <= 1'b0;
      graphics_queue_flip_o <= 1'b0;
      video_queue_flip_o <= 1'b0;
      frame_pulse_detect_o <= 1'b0;
      panel_height_o <= 10'h000;
      first_read_start_o <= 19'h00000;
      second_read_start_o <= 19'h00000;
      second_read_valid_o <= 1'b0;
      first_read_offset_o <= 13'h0000;
      write_start_o <= 22'h000000;
    end
    else
    begin
      hw_power_sequence_select_o <= seq_reg[`LPR_SEQ_HW]; // RQ2
      panel_timing_enable_o <= power_step_reg >= 3'h1; // RQ4
      panel_bias_enable_o <= power_step_reg >= 3'h2;
      panel_ctrl_enable_o <= power_step_reg >= 3'h3;
      panel_supply_enable_o <= power_step_reg >= 3'h4;
      cursor_blink_o <= blink_cnt_reg[{1'b0, blink_code_i} + 3'h3]; // RQ5
      char_blink_o <= blink_cnt_reg[{1'b0, blink_code_i} + 3'h4]; // RQ5
      line_pulse_o <= dual_scan_passive_panel && (lp_cnt_reg != 6'h00);
      shared_pin_o <= hhi_reg[5] ? m_signal_i : display_enable_i; // RQ9
      graphics_queue_flip_o <= hhi_reg[3]; // RQ10
      video_queue_flip_o <= hhi_reg[2];
      frame_pulse_detect_o <= hhi_reg[1];
      panel_height_o <= {hgt_hi_reg, hlo_reg}; // RQ12
      first_read_start_o <= {ovf_reg[5:3], r1h_reg, r1l_reg}; // RQ13 RQ14
      second_read_start_o <= {ovf_reg[2:0], r2h_reg, r2l_reg}; // RQ15
      second_read_valid_o <= decoupled && dual_scan_passive_panel; // RQ15
      first_read_offset_o <= {ovf_reg[7:6], r1o_reg, 3'h0}; // RQ16
      write_start_o <= {wov_reg[4:2], wbh_reg, wbl_reg, 3'h0}; // RQ17 RQ18
    end
  end
endmodule // lpr_panel_regs

/* rtl/lpr_store.v */
`include "lpr_defines.vh"

// ----------------------------------------
// byte store for the address and offset registers
// ----------------------------------------
module lpr_store (
  input wire clock_i, // system clock
  input wire wr_en_i, // write strobe
  input wire [3:0] wr_addr_i, // write entry
  input wire [7:0] wr_data_i, // write byte
  input wire [3:0] rd_addr_i, // read entry
  output reg [7:0] rd_data_o // registered read byte
);
  // no reset: contents are undefined at power-on
  reg [7:0] mem_reg [0:`LPR_STORE_DEPTH-1];

  // write port
  always @(posedge clock_i)
  begin
    if (wr_en_i)
    begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read, one cycle of latency
  always @(posedge clock_i)
  begin
    rd_data_o <= mem_reg[rd_addr_i];
  end
endmodule // lpr_store

/* verif/lpr_panel_model.sv */
module lpr_panel_model #(parameter int FRAME = 40) (
  input wire logic clock_i, // system clock
  input wire logic line_en_i, // emit line starts
  input wire logic [2:0] req_i, // request levels
  output logic vsync_o, // frame pulse
  output logic line_o, // line start pulse
  output logic odd_o, // frame parity
  output logic de_o, // display enable
  output logic m_o, // m-signal
  output logic [2:0] done_o // done pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0; // cycle in frame
  logic par = 1'b0; // frame parity
  logic [2:0] req_d = 3'h0; // delayed requests
  assign vsync_o = cnt == FRAME - 1;
  assign line_o = line_en_i && cnt == 5;
  assign de_o = cnt > 8 && cnt < 30;
  assign odd_o = par;
  assign m_o = par;
  // done pulses on alternate cycles while a request is high
  assign done_o = req_d & req_i;
  // frame counter, parity flips per frame
  always @(posedge clock_i)
  begin
    cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
    if (vsync_o)
      par <= !par;
    req_d <= req_i & ~req_d;
  end
endmodule // lpr_panel_model

/* verif/lpr_panel_regs_bench.sv */
module lpr_panel_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] index_i = 8'h00;
  logic data_wr_i = 1'b0;
  logic data_rd_i = 1'b0;
  logic [7:0] data_i = 8'h00;
  logic [7:0] refresh_ctrl_i = 8'h00;
  logic [1:0] panel_type_i = 2'h0;
  logic [1:0] step_code_i = 2'h0;
  logic [1:0] blink_code_i = 2'h0;
  logic power_request_i = 1'b0;
  logic line_en = 1'b0; // partner line starts
  logic vsync_pulse_i, line_start_i, frame_odd_i, display_enable_i, m_signal_i;
  logic gflip_done_i, vflip_done_i, frame_pulse_seen_i, data_valid_o, line_pulse_o;
  logic hw_power_sequence_select_o, panel_timing_enable_o, panel_bias_enable_o;
  logic panel_ctrl_enable_o, panel_supply_enable_o, cursor_blink_o, char_blink_o;
  logic shared_pin_o, graphics_queue_flip_o, video_queue_flip_o, frame_pulse_detect_o;
  logic second_read_valid_o;
  logic [7:0] data_o;
  logic [9:0] panel_height_o;
  logic [18:0] first_read_start_o, second_read_start_o;
  logic [12:0] first_read_offset_o;
  logic [21:0] write_start_o;
  logic [2:0] done_w;
  logic [7:0] m [0:255]; // expected contents
  logic [7:0] idx [0:12] = '{8'h34, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42, 8'h43,
    8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49};
  logic [7:0] v;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;
  always #5 clock_i = !clock_i;
  assign {gflip_done_i, vflip_done_i, frame_pulse_seen_i} = done_w;
  lpr_panel_regs u_dut (.*);
  lpr_panel_model u_panel (.clock_i(clock_i), .line_en_i(line_en),
    .req_i({graphics_queue_flip_o, video_queue_flip_o, frame_pulse_detect_o}),
    .vsync_o(vsync_pulse_i), .line_o(line_start_i), .odd_o(frame_odd_i),
    .de_o(display_enable_i), .m_o(m_signal_i), .done_o(done_w));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // strobe held for its taking edge, one idle edge after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    index_i <= a;
    data_i <= d;
    data_wr_i <= 1'b1;
    @(posedge clock_i);
    data_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    index_i <= a;
    data_rd_i <= 1'b1;
    @(posedge clock_i);
    data_rd_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    chk("read valid", data_valid_o, 1'b1);
    d = data_o;
    @(posedge clock_i);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return panel_timing_enable_o;
      1: return panel_bias_enable_o;
      2: return line_pulse_o;
      3: return cursor_blink_o;
      4: return char_blink_o;
      5: return vsync_pulse_i;
      6: return frame_pulse_detect_o;
      7: return video_queue_flip_o;
      default: return graphics_queue_flip_o;
    endcase
  endfunction
  // bounded wait, settled values sampled mid-cycle
  task automatic waitv(input int s, input logic val, input int lim);
    @(negedge clock_i);
    for (int k = 0; k < lim && pick(s) !== val; k++)
      @(negedge clock_i);
  endtask
  // frames counted until the watched signal reaches val
  task automatic count_vs(input int s, input logic val, output int c);
    c = 0;
    while (pick(s) !== val && c < 300)
    begin
      @(negedge clock_i);
      c += int'(vsync_pulse_i);
    end
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hd3b3));
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rd(8'h34, v);
    chk("sequence reset", v, 8'h80);
    rd(8'h35, v);
    chk("unmapped", v, 8'h00);
    $display("test reset done");
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 13; i++)
      begin
        v = 8'($urandom);
        if (idx[i] == 8'h3E)
          v = v & 8'h83;
        if (idx[i] == 8'h3F)
          v = v & 8'hFE;
        m[idx[i]] = v;
        wr(idx[i], v);
      end
      for (int i = 0; i < 13; i++)
      begin
        rd(idx[i], v);
        chk("readback", v, m[idx[i]]);
      end
      chk("height", panel_height_o, {m[8'h3E][1:0], m[8'h3F]});
      chk("first start", first_read_start_o, {m[8'h45][5:3], m[8'h41], m[8'h40]});
      chk("second start", second_read_start_o, {m[8'h45][2:0], m[8'h43], m[8'h42]});
      chk("offset", first_read_offset_o, {m[8'h45][7:6], m[8'h44], 3'h0});
      chk("write start", write_start_o, {m[8'h49][4:2], m[8'h47], m[8'h46], 3'h0});
    end
    $display("test registers done");
    wr(8'h34, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      refresh_ctrl_i <= {k[2], 7'($urandom)};
      panel_type_i <= k[1:0];
      repeat (4) @(posedge clock_i);
      chk("second valid", second_read_valid_o, k[2] && k[1:0] == 2'h1);
    end
    panel_type_i <= 2'h0;
    refresh_ctrl_i <= 8'h00;
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h3E, {k[1], 7'h00});
      waitv(5, 1'b1, 100);
      repeat (15) @(negedge clock_i);
      chk("shared pin", shared_pin_o, k[1] ? m_signal_i : display_enable_i);
      repeat (20) @(negedge clock_i);
      chk("shared pin idle", shared_pin_o, k[1] ? m_signal_i : 1'b0);
      @(posedge clock_i);
    end
    for (int b = 3; b < 6; b++)
    begin
      wr(8'h3E, 8'(1 << b));
      @(negedge clock_i);
      chk("request set", pick(b + 3), 1'b1);
      @(posedge clock_i);
      v = 8'hFF;
      for (int t = 0; t < 10 && v[b]; t++)
        rd(8'h3E, v);
      chk("request cleared", v[b], 1'b0);
    end
    $display("test fields done");
    wr(8'h34, 8'h80);
    for (int c = 0; c < 4; c++)
    begin
      step_code_i <= c[1:0];
      power_request_i <= 1'b0;
      waitv(0, 1'b0, 3000);
      @(posedge clock_i);
      power_request_i <= 1'b1;
      waitv(0, 1'b1, 3000);
      count_vs(1, 1'b1, n);
      chk("step frames", n, 1 << c);
      @(posedge clock_i);
    end
    wr(8'h34, 8'h00);
    power_request_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk("sw off", {panel_timing_enable_o, panel_bias_enable_o, panel_ctrl_enable_o,
      panel_supply_enable_o}, 4'h0);
    chk("hw select", hw_power_sequence_select_o, 1'b0);
    power_request_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk("sw on", {panel_timing_enable_o, panel_bias_enable_o, panel_ctrl_enable_o,
      panel_supply_enable_o}, 4'hF);
    $display("test power done");
    line_en <= 1'b1;
    panel_type_i <= 2'h1;
    for (int w = 0; w < 2; w++)
    begin
      wr(8'h34, {1'b0, w[0], 6'h00});
      waitv(2, 1'b0, 100);
      waitv(2, 1'b1, 100);
      for (n = 0; line_pulse_o === 1'b1 && n < 100; n++)
        @(negedge clock_i);
      chk("pulse width", n, w ? 32 : 16);
      @(posedge clock_i);
    end
    line_en <= 1'b0;
    wr(8'h3E, 8'h04);
    waitv(2, 1'b1, 1100);
    chk("free pulse on", line_pulse_o, 1'b1);
    @(posedge clock_i);
    wr(8'h3E, 8'h00);
    waitv(2, 1'b0, 100);
    waitv(2, 1'b1, 1100);
    chk("free pulse off", line_pulse_o, 1'b0);
    @(posedge clock_i);
    wr(8'h34, 8'h21);
    for (int f = 0; f < 3; f++)
    begin
      @(posedge clock_i);
      refresh_ctrl_i <= {f[1], 7'h00};
      waitv(5, 1'b1, 100);
      v = {7'h00, frame_odd_i};
      n = 0;
      repeat (38)
      begin
        @(negedge clock_i);
        n += int'(line_pulse_o && !v[1]);
        v[1] = line_pulse_o;
      end
      chk("extra pulses", n, (v[0] && !f[1]) ? 2 : 1);
    end
    $display("test line pulse done");
    for (int c = 0; c < 3; c++)
    begin
      @(posedge clock_i);
      blink_code_i <= c[1:0];
      repeat (2) @(negedge clock_i);
      for (int s = 3; s < 5; s++)
      begin
        count_vs(s, !pick(s), n);
        count_vs(s, !pick(s), n);
        chk("blink frames", n, (s == 3 ? 8 : 16) << c);
      end
    end
    $display("test blink done");
    end_sim();
  end
  // hang guard, well beyond the expected run
  initial
  begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // lpr_panel_regs_bench

/* verif/lpr_panel_regs_sva.sv */
module lpr_panel_regs_sva (
  input wire logic clock_i, // system clock
  input wire logic reset_i, // sync reset
  input wire logic data_rd_i, // read strobe
  input wire logic data_valid_o, // read answer
  input wire logic hw_power_sequence_select_o, // hw sequencing
  input wire logic power_request_i, // panel on request
  input wire logic panel_timing_enable_o, // step one
  input wire logic panel_bias_enable_o, // step two
  input wire logic panel_ctrl_enable_o, // step three
  input wire logic panel_supply_enable_o, // step four
  input wire logic gflip_done_i, // done pulse
  input wire logic vflip_done_i, // done pulse
  input wire logic frame_pulse_seen_i, // done pulse
  input wire logic graphics_queue_flip_o, // request level
  input wire logic video_queue_flip_o, // request level
  input wire logic frame_pulse_detect_o, // request level
  input wire logic line_pulse_o, // passive line pulse
  input wire logic [7:0] refresh_ctrl_i, // refresh control
  input wire logic [1:0] panel_type_i, // panel type
  input wire logic second_read_valid_o // second start in use
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helper: length of the current line pulse
  // ----------------------------------------
  logic [6:0] lp_len; // high cycles so far
  always @(posedge clock_i)
  begin
    if (reset_i || !line_pulse_o)
      lp_len <= 7'h00;
    else
      lp_len <= lp_len + 7'h01;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  rd_answer_a: assert property (data_rd_i |-> ##2 data_valid_o)
    else $error("read not answered after two cycles");
  valid_cause_a: assert property (data_valid_o |-> $past(data_rd_i, 2))
    else $error("read answer without a read");
  seq_default_a: assert property ($fell(reset_i) |-> hw_power_sequence_select_o)
    else $error("hardware sequencing not chosen after reset");
  sw_follow_a: assert property ((!hw_power_sequence_select_o && $stable(power_request_i))[*3]
    |-> panel_supply_enable_o == power_request_i)
    else $error("software mode supply not following request");
  hw_order_a: assert property (hw_power_sequence_select_o && panel_supply_enable_o
    |-> panel_ctrl_enable_o && panel_bias_enable_o && panel_timing_enable_o)
    else $error("supply on before earlier steps");
  gflip_clear_a: assert property (gflip_done_i |-> ##2 !graphics_queue_flip_o)
    else $error("graphics flip not cleared");
  vflip_clear_a: assert property (vflip_done_i |-> ##2 !video_queue_flip_o)
    else $error("video flip not cleared");
  detect_clear_a: assert property (frame_pulse_seen_i |-> ##2 !frame_pulse_detect_o)
    else $error("frame detect not cleared");
  lp_width_a: assert property ($fell(line_pulse_o) |-> lp_len == 7'h10 || lp_len == 7'h20)
    else $error("line pulse width not 16 or 32");
  second_valid_a: assert property (!$past(reset_i) && $stable(refresh_ctrl_i[7])
    && $stable(panel_type_i) |=> second_read_valid_o ==
    ($past(refresh_ctrl_i[7]) && $past(panel_type_i) == 2'h1))
    else $error("second start validity wrong");
endmodule // lpr_panel_regs_sva
bind lpr_panel_regs lpr_panel_regs_sva u_sva (.*);
